// File: common/trc_pkg.sv
// ----------------------------------------------------------------------------
// timer run / overflow control constants
// ----------------------------------------------------------------------------
package trc_pkg;

    // ------------------------------------------------------------------------
    // special function register placement
    // ------------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h88;  // byte address of the control byte
    localparam logic [3:0] CTRL_PAGE = 4'h0;   // register page of the control byte
    localparam logic [4:0] CTRL_BIT_BASE = 5'h11; // bit address [7:3] = 0x88 >> 3
    localparam logic [7:0] CTRL_RESET = 8'h00; // whole byte after reset

    // ------------------------------------------------------------------------
    // field positions inside the control byte
    // ------------------------------------------------------------------------
    localparam int TIMER1_OVERFLOW_FLAG = 7;
    localparam int TIMER1_RUN_ENABLE = 6;
    localparam int TIMER0_OVERFLOW_FLAG = 5;
    localparam int TIMER0_RUN_ENABLE = 4;
    localparam int EXT_IRQ1_FLAG = 3;
    localparam int EXT_IRQ1_TYPE = 2;
    localparam int EXT_IRQ0_FLAG = 1;
    localparam int EXT_IRQ0_TYPE = 0;

    // ------------------------------------------------------------------------
    // read data after reset
    // ------------------------------------------------------------------------
    localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : trc_pkg

// File: verilog/trc_timer_ctrl.sv
// How it works
// - outside split mode, a Timer 1 overflow sets the Timer 1 overflow flag in bit 7 of the control byte.
// - the Timer 1 flag clears on a software write of zero or when the core vectors to its ISR.
// - a Timer 0 overflow sets the Timer 0 overflow flag in bit 5 of the control byte.
// - the Timer 0 flag clears on a software write of zero or when the core vectors to its ISR.
// - bit 6 is the Timer 1 run enable: one lets Timer 1 count, zero stops it, except in split mode where Timer 1 counts regardless.
// - bit 4 is the Timer 0 run enable: one lets Timer 0 count subject to gating, zero stops it.
// - the byte sits at register address 0x88 on page 0x0 and each bit can be written alone.
// - in split mode an overflow of the Timer 0 high half sets the Timer 1 overflow flag.
// - in split mode the Timer 1 run enable controls counting of the Timer 0 high half.
// - a running Timer 0, or Timer 1 outside split mode, counts only with its gate off or its external input at active level.
`timescale 1ns/1ps
`default_nettype none

module trc_timer_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register bus, byte access
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // register bus, single bit write
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    // timer overflow events and core vectoring
    input wire logic timer0_ovf,
    input wire logic timer0_high_ovf,
    input wire logic timer1_ovf,
    input wire logic timer0_isr_vector,
    input wire logic timer1_isr_vector,
    // mode and gating from the mode register logic
    input wire logic timer0_split_mode,
    input wire logic timer0_gate_control,
    input wire logic timer1_gate_control,
    input wire logic ext_irq0_polarity,
    input wire logic ext_irq1_polarity,
    // external interrupt pins, asynchronous
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    // control byte and count enables
    output logic [7:0] timer_run_overflow_control,
    output logic timer0_count_en,
    output logic timer0_high_count_en,
    output logic timer1_count_en
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] next_rdata;
    logic [1:0] irq_sync1;
    logic [1:0] irq_sync2;
    logic byte_hit;
    logic bit_hit;
    logic [2:0] bit_sel;
    logic set_t0;
    logic set_t1;
    logic irq0_active;
    logic irq1_active;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // two stages on each external interrupt pin before gating reads it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_sync1 <= 2'h0;
            irq_sync2 <= 2'h0;
        end else begin
            irq_sync1 <= {ext_irq1_input, ext_irq0_input};
            irq_sync2 <= irq_sync1;
        end
    end

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    // byte and bit decode
    assign byte_hit = (sfr_page == trc_pkg::CTRL_PAGE) && (sfr_addr == trc_pkg::CTRL_ADDR);
    assign bit_hit = bit_wr && (sfr_page == trc_pkg::CTRL_PAGE)
                     && (bit_addr[7:3] == trc_pkg::CTRL_BIT_BASE);
    assign bit_sel = bit_addr[2:0];

    // ------------------------------------------------------------------------
    // overflow event routing
    // ------------------------------------------------------------------------
    // high half owns flag
    assign set_t1 = timer0_split_mode ? timer0_high_ovf : timer1_ovf;
    assign set_t0 = timer0_ovf;

    // ------------------------------------------------------------------------
    // control byte next value
    // ------------------------------------------------------------------------
    // software writes first, then vector clears, hardware sets win last
    always_comb begin
        next_ctrl = ctrl;
        if (sfr_wr && byte_hit) begin
            next_ctrl = sfr_wdata;
        end
        if (bit_hit) begin
            next_ctrl[bit_sel] = bit_wdata;
        end
        if (timer1_isr_vector) begin
            next_ctrl[trc_pkg::TIMER1_OVERFLOW_FLAG] = 1'b0;
        end
        if (timer0_isr_vector) begin
            next_ctrl[trc_pkg::TIMER0_OVERFLOW_FLAG] = 1'b0;
        end
        if (set_t1) begin
            next_ctrl[trc_pkg::TIMER1_OVERFLOW_FLAG] = 1'b1;
        end
        if (set_t0) begin
            next_ctrl[trc_pkg::TIMER0_OVERFLOW_FLAG] = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // read data next value
    // ------------------------------------------------------------------------
    // unmapped reads return zero
    always_comb begin
        next_rdata = trc_pkg::RDATA_RESET;
        if (sfr_rd && byte_hit) begin
            next_rdata = ctrl;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    // reset to zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= trc_pkg::CTRL_RESET;
            sfr_rdata <= trc_pkg::RDATA_RESET;
        end else begin
            ctrl <= next_ctrl;
            sfr_rdata <= next_rdata;
        end
    end

    assign timer_run_overflow_control = ctrl;

    // ------------------------------------------------------------------------
    // count enables
    // ------------------------------------------------------------------------
    // gate against active level
    assign irq0_active = (irq_sync2[0] == ext_irq0_polarity);
    assign irq1_active = (irq_sync2[1] == ext_irq1_polarity);

    assign timer0_count_en = ctrl[trc_pkg::TIMER0_RUN_ENABLE]
                             && (!timer0_gate_control || irq0_active);
    assign timer0_high_count_en = timer0_split_mode && ctrl[trc_pkg::TIMER1_RUN_ENABLE];
    // timer 1 run, its own mode decides while timer 0 is split
    assign timer1_count_en = timer0_split_mode
                             || (ctrl[trc_pkg::TIMER1_RUN_ENABLE]
                                 && (!timer1_gate_control || irq1_active));

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_t1_ovf_sets: assert property (!timer0_split_mode && timer1_ovf |=> ctrl[7])
        else $error("timer 1 overflow did not set its flag");
    a_t1_vec_clears: assert property (
        timer1_isr_vector && !set_t1 && !bit_hit && !(sfr_wr && byte_hit) |=> !ctrl[7])
        else $error("timer 1 vector did not clear its flag");
    a_t0_ovf_sets: assert property (
        timer0_ovf |=> ctrl[5] ##1 ctrl[5] || $past(timer0_isr_vector)
        || $past(sfr_wr) || $past(bit_wr))
        else $error("timer 0 overflow flag lost");
    a_t0_vec_clears: assert property (
        timer0_isr_vector && !timer0_ovf && !bit_hit && !(sfr_wr && byte_hit) |=> !ctrl[5])
        else $error("timer 0 vector did not clear its flag");
    a_t1_run_stop: assert property (!timer0_split_mode && !ctrl[6] |-> !timer1_count_en)
        else $error("timer 1 counts while stopped");
    a_t0_run_stop: assert property (!ctrl[4] |-> !timer0_count_en)
        else $error("timer 0 counts while stopped");
    a_byte_write: assert property (
        sfr_wr && byte_hit && !bit_wr && !timer0_ovf && !timer1_ovf
        && !timer0_high_ovf && !timer0_isr_vector && !timer1_isr_vector
        |=> ctrl == $past(sfr_wdata))
        else $error("byte write to control byte lost");
    a_bit_write: assert property (
        bit_hit && bit_sel == 3'h4 && !sfr_wr
        |=> ctrl[4] == $past(bit_wdata))
        else $error("bit write to run enable lost");
    a_page_ignored: assert property (
        sfr_wr && sfr_page != 4'h0 && !bit_wr && !timer0_ovf
        && !timer1_ovf && !timer0_high_ovf && !timer0_isr_vector && !timer1_isr_vector
        |=> $stable(ctrl))
        else $error("write to another page changed the control byte");
    a_split_sets: assert property (timer0_split_mode && timer0_high_ovf |=> ctrl[7])
        else $error("high half overflow did not set timer 1 flag");
    a_split_blocks: assert property (
        timer0_split_mode && !timer0_high_ovf && !ctrl[7]
        && !bit_wr && !(sfr_wr && byte_hit) |=> !ctrl[7])
        else $error("timer 1 set its flag in split mode");
    a_high_run: assert property (timer0_split_mode |-> timer0_high_count_en == ctrl[6])
        else $error("high half enable does not follow timer 1 run");
    a_t0_gate: assert property (
        ctrl[4] && timer0_gate_control && $stable(ext_irq0_polarity)
        && (ext_irq0_input != ext_irq0_polarity)
        ##1 ($stable(ext_irq0_input) && $stable(ext_irq0_polarity) && timer0_gate_control)[*2]
        |-> !timer0_count_en)
        else $error("gated timer 0 counts with input inactive");
    a_read_back: assert property (sfr_rd && byte_hit |=> sfr_rdata == $past(ctrl))
        else $error("read data differs from control byte");

    c_t1_overflow: cover property (timer1_ovf && !timer0_split_mode ##1 timer1_isr_vector);
    c_split_high: cover property (timer0_split_mode && timer0_high_ovf);
    c_set_vs_clear: cover property (timer0_ovf && timer0_isr_vector);
    c_gated_run: cover property (ctrl[4] && timer0_gate_control && timer0_count_en);

endmodule // trc_timer_ctrl

`default_nettype wire

// File: bench/trc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// core vectoring model
// ----------------------------
module trc_core_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // control byte and model settings
    input wire logic [7:0] ctrl,
    input wire logic ie,
    input wire logic [3:0] lat,
    // vector pulses
    output logic t0_vec,
    output logic t1_vec
);
    // vector to a pending timer after lat cycles, timer 1 first
    initial begin
        t0_vec = 1'b0;
        t1_vec = 1'b0;
        forever begin
            @(negedge mclk);
            if (rstn && ie && (ctrl[7] || ctrl[5])) begin
                repeat (lat) @(negedge mclk);
                t1_vec = ctrl[7];
                t0_vec = !ctrl[7] && ctrl[5];
                @(negedge mclk);
                t1_vec = 1'b0;
                t0_vec = 1'b0;
                @(negedge mclk);
            end
        end
    end
endmodule // trc_core_model
`default_nettype wire

// File: bench/timer01_run_overflow_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// bench top
// ----------------------------
module timer01_run_overflow_control_test;
    logic mclk, rstn, sfr_wr, sfr_rd, bit_wr, bit_wdata, t0o, t0ho, t1o, split, g0, g1, p0, p1;
    logic i0, i1, ie, t0v, t1v, en0, en0h, en1, rd_pend, e;
    logic [3:0] page, lat;
    logic [7:0] addr, wdata, rdata, baddr, ctrl, shadow;
    logic [7:0] q[$];
    int miscompares, tests_run;

    trc_timer_ctrl uut (.mclk(mclk), .rstn(rstn), .sfr_page(page), .sfr_addr(addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .bit_wr(bit_wr), .bit_addr(baddr), .bit_wdata(bit_wdata), .timer0_ovf(t0o),
        .timer0_high_ovf(t0ho), .timer1_ovf(t1o), .timer0_isr_vector(t0v),
        .timer1_isr_vector(t1v), .timer0_split_mode(split), .timer0_gate_control(g0),
        .timer1_gate_control(g1), .ext_irq0_polarity(p0), .ext_irq1_polarity(p1),
        .ext_irq0_input(i0), .ext_irq1_input(i1), .timer_run_overflow_control(ctrl),
        .timer0_count_en(en0), .timer0_high_count_en(en0h), .timer1_count_en(en1));
    trc_core_model core (.mclk(mclk), .rstn(rstn), .ctrl(ctrl), .ie(ie), .lat(lat),
        .t0_vec(t0v), .t1_vec(t1v));

    // clock at 250 MHz
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_en(input logic [2:0] got, input logic [2:0] exp);
        check({5'h00, got}, {5'h00, exp});
    endtask

    task automatic give_verdict;
        $display("counts: run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        page = pg;
        addr = a;
        wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
        page = 4'h0;
    endtask

    task automatic rd(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] x);
        @(negedge mclk);
        page = pg;
        addr = a;
        sfr_rd = 1'b1;
        q.push_back(x);
        @(negedge mclk);
        sfr_rd = 1'b0;
        page = 4'h0;
    endtask

    task automatic bitw(input logic [7:0] a, input logic v);
        @(negedge mclk);
        baddr = a;
        bit_wdata = v;
        bit_wr = 1'b1;
        @(negedge mclk);
        bit_wr = 1'b0;
    endtask

    task automatic ev(input logic [2:0] x);
        @(negedge mclk);
        {t1o, t0ho, t0o} = x;
        @(negedge mclk);
        {t1o, t0ho, t0o} = 3'b000;
    endtask

    // read data is compared one cycle after the read is taken
    always @(posedge mclk) rd_pend <= sfr_rd;
    always @(negedge mclk) if (rd_pend) check(rdata, q.pop_front());

    // watchdog
    initial begin
        #40000;
        miscompares++;
        give_verdict;
    end

    // main sequence
    initial begin
        {sfr_wr, sfr_rd, bit_wr, bit_wdata, t0o, t0ho, t1o, split, g0, g1} = 10'h000;
        {p0, p1, i0, i1, ie, rstn} = 6'h00;
        {page, lat, addr, wdata, baddr} = 32'h0000_0000;
        void'($urandom(62786));
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        rd(4'h0, 8'h88, 8'h00);
        check_en({en0, en0h, en1}, 3'h0);
        $display("test reset done");
        shadow = {4'h5, 4'($urandom)};
        wr(4'h0, 8'h88, shadow);
        rd(4'h0, 8'h88, shadow);
        check_en({en0, en0h, en1}, 3'h5);
        wr(4'h1, 8'h88, 8'hff);
        wr(4'h0, 8'h89, 8'hff);
        rd(4'h1, 8'h88, 8'h00);
        rd(4'h0, 8'h88, shadow);
        for (int i = 0; i < 8; i++) begin
            bitw(8'h88 + 8'(i), !shadow[i]);
            shadow[i] = !shadow[i];
            rd(4'h0, 8'h88, shadow);
        end
        wr(4'h0, 8'h88, 8'h00);
        rd(4'h0, 8'h88, 8'h00);
        $display("test register access done");
        ev(3'b001);
        rd(4'h0, 8'h88, 8'h20);
        ev(3'b100);
        rd(4'h0, 8'h88, 8'ha0);
        for (int k = 0; k < 2; k++) begin
            lat = k ? 4'h9 : 4'h1;
            ie = 1'b1;
            repeat (40) @(negedge mclk);
            ie = 1'b0;
            rd(4'h0, 8'h88, 8'h00);
            ev(3'b101);
        end
        wr(4'h0, 8'h88, 8'h00);
        ev(3'b010);
        rd(4'h0, 8'h88, 8'h00);
        // software clear and overflow in one cycle, the set wins
        @(negedge mclk);
        {addr, wdata, sfr_wr, t0o} = {8'h88, 8'h00, 1'b1, 1'b1};
        @(negedge mclk);
        {sfr_wr, t0o} = 2'h0;
        rd(4'h0, 8'h88, 8'h20);
        $display("test flags done");
        split = 1'b1;
        wr(4'h0, 8'h88, 8'h40);
        check_en({en0, en0h, en1}, 3'h3);
        ev(3'b100);
        rd(4'h0, 8'h88, 8'h40);
        ev(3'b010);
        rd(4'h0, 8'h88, 8'hc0);
        split = 1'b0;
        wr(4'h0, 8'h88, 8'h50);
        $display("test split done");
        for (int i = 0; i < 8; i++) begin
            {g0, p0, i0} = 3'(i);
            {g1, p1, i1} = 3'(i);
            repeat (3) @(negedge mclk);
            e = !g0 || (i0 == p0);
            check_en({en0, en0h, en1}, {e, 1'b0, e});
        end
        $display("test gating done");
        repeat (6) begin
            shadow = 8'($urandom);
            wr(4'h0, 8'h88, shadow);
            check(ctrl, shadow);
            rd(4'h0, 8'h88, shadow);
        end
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        rd(4'h0, 8'h88, 8'h00);
        $display("test random and reset done");
        repeat (2) @(negedge mclk);
        give_verdict;
    end
endmodule // timer01_run_overflow_control_test
`default_nettype wire
